//--- common/adcst_defines.svh
// Register map, field positions, reset values and timing counts of the
// conversion start and tracking controller.
// Assumes inclusion by the top module and by the testbench.
`ifndef ADCST_DEFINES_SVH
`define ADCST_DEFINES_SVH

`define ADCST_OFF_CTRL 8'h00
`define ADCST_OFF_CFG 8'h04
`define ADCST_OFF_RESULT 8'h08
`define ADCST_OFF_STATUS 8'h0c

`define ADCST_C_EN 0
`define ADCST_C_BUSY 1
`define ADCST_C_DONE 2
`define ADCST_C_SRC 5:4
`define ADCST_C_EOCIE 6
`define ADCST_C_WINIE 7
`define ADCST_C_BURST 8
`define ADCST_C_LPIDLE 9
`define ADCST_C_LJUST 10

`define ADCST_G_TMODE 1:0
`define ADCST_G_TK 5:2
`define ADCST_G_DIV 12:8
`define ADCST_G_RPT 17:16
`define ADCST_G_PWRUP 31:24

`define ADCST_S_STATE 2:0
`define ADCST_S_TRACK 3
`define ADCST_S_PWR 4

`define ADCST_CTRL_RST 32'h0000_0000
`define ADCST_CTRL_WMASK 32'h0000_07f1
`define ADCST_CFG_RST 32'h0000_0001
`define ADCST_CFG_WMASK 32'hff01_1f3f

`define ADCST_TRACK_EXTRA 8'h01
`define ADCST_CONV_STEPS 4'hd
`define ADCST_CONV_LAST 4'hc

`define ADCST_RESP_OKAY 2'b00
`define ADCST_RESP_SLVERR 2'b10

`endif

//--- common/adcst_pkg.sv
// Types shared by the conversion start and tracking controller files.
// Assumes the defines header sits beside it on the include path.
package adcst_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_PWRUP = 3'b001,
		ST_TRACK = 3'b010,
		ST_CSTART = 3'b011,
		ST_CONV = 3'b100,
		ST_FINISH = 3'b101
	} adcst_state_type;

	typedef enum logic [1:0]
	{
		SRC_SW = 2'b00,
		SRC_EXT = 2'b01,
		SRC_T1 = 2'b10,
		SRC_T2 = 2'b11
	} adcst_src_type;

	typedef enum logic [1:0]
	{
		TM_RSVD = 2'b00,
		TM_POST = 2'b01,
		TM_PRE = 2'b10,
		TM_DUAL = 2'b11
	} adcst_tmode_type;

	typedef struct packed {
		logic [4:0] cnt;
	} adcst_div_state_type;

	typedef struct packed {
		logic ext_prev;
	} adcst_trig_state_type;

	typedef struct packed {
		adcst_state_type st;
		logic [7:0] cnt;
		logic [3:0] steps;
		logic [3:0] rpt_left;
		logic [15:0] accum;
		logic [15:0] result;
		logic done;
		logic powered;
		logic [31:0] ctrl;
		logic [31:0] cfg;
		logic aw_ok;
		logic [7:0] awaddr;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} adcst_top_state_type;

endpackage

//--- src/adcst_clkdiv.sv
// Conversion step clock: one-cycle step pulse every divider+1 clocks.
// Assumes run is held for the whole converting phase.
`timescale 1ns/10ps
module adcst_clkdiv
	import adcst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [4:0] div,
	output logic step
);
	adcst_div_state_type s_q;
	adcst_div_state_type s_d;

	// Counter restarts with each run so every conversion sees equal steps
	always_comb
	begin
		s_d = s_q;
		if (!run)
			s_d.cnt = 5'h00;
		else if (s_q.cnt == div)
			s_d.cnt = 5'h00;
		else
			s_d.cnt = s_q.cnt + 5'h01;
	end

	assign step = run && (s_q.cnt == div);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

//--- src/adcst_top.sv
// Conversion start and tracking controller with its AXI4-Lite registers.
// Assumes one clock that also serves as the converter subsystem clock and
// an analog core that returns a 12-bit result while sar_run is high.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module adcst_top
	import adcst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_convert_start,
	input wire logic timer1_ovf,
	input wire logic timer2_low_ovf,
	input wire logic timer2_high_ovf,
	input wire logic timer2_split_mode,
	input wire logic [11:0] sar_result,
	output logic conversion_busy_bit,
	output logic conversion_done_flag,
	output logic eoc_irq_req,
	output logic window_irq_en,
	output logic track_en,
	output logic sar_run,
	output logic sar_step,
	output logic converter_powered
);
`include "adcst_defines.svh"

	adcst_top_state_type s_q;
	adcst_top_state_type s_d;
	logic en;
	logic burst;
	adcst_src_type src;
	adcst_tmode_type tmode;
	adcst_tmode_type eff_mode;
	logic wr_go;
	logic wr_ctrl;
	logic sw_start;
	logic done_clr;
	logic start;
	logic step;
	logic [7:0] track_init;
	logic [15:0] sum;

	function automatic logic [31:0] adcst_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r & mask;
	endfunction

	function automatic logic [3:0] adcst_rpt_left(input logic [1:0] code);
		case (code)
			2'b00: return 4'h0;
			2'b01: return 4'h3;
			2'b10: return 4'h7;
			default: return 4'hf;
		endcase
	endfunction

	function automatic logic adcst_mapped(input logic [7:0] a);
		return a == `ADCST_OFF_CTRL || a == `ADCST_OFF_CFG
			|| a == `ADCST_OFF_RESULT || a == `ADCST_OFF_STATUS;
	endfunction

	assign en = s_q.ctrl[`ADCST_C_EN];
	assign burst = s_q.ctrl[`ADCST_C_BURST];
	assign src = adcst_src_type'(s_q.ctrl[`ADCST_C_SRC]);
	assign tmode = adcst_tmode_type'(s_q.cfg[`ADCST_G_TMODE]);

	// Pre-tracking needs software timing, so burst falls back to post
	always_comb
	begin
		case (tmode)
			TM_PRE: eff_mode = burst ? TM_POST : TM_PRE;
			TM_DUAL: eff_mode = TM_DUAL;
			TM_POST: eff_mode = TM_POST;
			default: eff_mode = TM_POST;
		endcase
	end

	assign track_init = {4'h0, s_q.cfg[`ADCST_G_TK]}
		+ `ADCST_TRACK_EXTRA;
	assign sum = s_q.accum + {4'h0, sar_result};

	assign wr_go = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
	assign wr_ctrl = wr_go && s_q.awaddr == `ADCST_OFF_CTRL && s_q.wstrb[0];
	assign sw_start = wr_ctrl && s_q.wdata[`ADCST_C_BUSY];
	assign done_clr = wr_ctrl && !s_q.wdata[`ADCST_C_DONE];

	adcst_trigger u_trig
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.src(src),
		.sw_start(sw_start),
		.external_convert_start(external_convert_start),
		.timer1_ovf(timer1_ovf),
		.timer2_low_ovf(timer2_low_ovf),
		.timer2_high_ovf(timer2_high_ovf),
		.timer2_split_mode(timer2_split_mode),
		.start(start)
	);

	adcst_clkdiv u_div
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.run(s_q.st == ST_CONV),
		.div(s_q.cfg[`ADCST_G_DIV]),
		.step(step)
	);

	always_comb
	begin
		s_d = s_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_ok = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_ok = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (wr_go)
		begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = adcst_mapped(s_q.awaddr) ? `ADCST_RESP_OKAY
				: `ADCST_RESP_SLVERR;
			if (s_q.awaddr == `ADCST_OFF_CTRL)
				s_d.ctrl = adcst_merge(s_q.ctrl, s_q.wdata, s_q.wstrb,
					`ADCST_CTRL_WMASK);
			if (s_q.awaddr == `ADCST_OFF_CFG)
				s_d.cfg = adcst_merge(s_q.cfg, s_q.wdata, s_q.wstrb,
					`ADCST_CFG_WMASK);
		end
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = adcst_mapped(s_axi_araddr) ? `ADCST_RESP_OKAY
				: `ADCST_RESP_SLVERR;
			s_d.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				`ADCST_OFF_CTRL:
				begin
					s_d.rdata = s_q.ctrl;
					s_d.rdata[`ADCST_C_BUSY] = conversion_busy_bit;
					s_d.rdata[`ADCST_C_DONE] = s_q.done;
				end
				`ADCST_OFF_CFG: s_d.rdata = s_q.cfg;
				`ADCST_OFF_RESULT: s_d.rdata = {16'h0000, s_q.result};
				`ADCST_OFF_STATUS:
				begin
					s_d.rdata[`ADCST_S_STATE] = s_q.st;
					s_d.rdata[`ADCST_S_TRACK] = track_en;
					s_d.rdata[`ADCST_S_PWR] = s_q.powered;
				end
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end

		case (s_q.st)
			ST_IDLE:
			begin
				if (!burst)
					s_d.powered = en;
				else if (s_q.ctrl[`ADCST_C_LPIDLE])
					s_d.powered = 1'b0;
				if (start && en)
				begin
					s_d.rpt_left = adcst_rpt_left(
						s_q.cfg[`ADCST_G_RPT]);
					s_d.accum = 16'h0000;
					if (burst && !s_q.powered)
					begin
						s_d.st = ST_PWRUP;
						s_d.cnt = s_q.cfg[`ADCST_G_PWRUP];
					end
					else if (eff_mode == TM_PRE)
						s_d.st = ST_CSTART;
					else
					begin
						s_d.st = ST_TRACK;
						s_d.cnt = track_init;
					end
				end
			end
			ST_PWRUP:
			begin
				if (s_q.cnt == 8'h00)
				begin
					s_d.powered = 1'b1;
					if (eff_mode == TM_PRE)
						s_d.st = ST_CSTART;
					else
					begin
						s_d.st = ST_TRACK;
						s_d.cnt = track_init;
					end
				end
				else
					s_d.cnt = s_q.cnt - 8'h01;
			end
			ST_TRACK:
			begin
				if (s_q.cnt == 8'h00)
					s_d.st = ST_CSTART;
				else
					s_d.cnt = s_q.cnt - 8'h01;
			end
			ST_CSTART:
			begin
				s_d.st = ST_CONV;
				s_d.steps = 4'h0;
			end
			ST_CONV:
			begin
				if (step)
				begin
					s_d.steps = s_q.steps + 4'h1;
					if (s_q.steps == `ADCST_CONV_LAST)
						s_d.st = ST_FINISH;
				end
			end
			ST_FINISH:
			begin
				s_d.accum = sum;
				if (s_q.rpt_left == 4'h0)
				begin
					s_d.st = ST_IDLE;
					s_d.result = s_q.ctrl[`ADCST_C_LJUST]
						? {sum[11:0], 4'h0} : sum;
				end
				else
				begin
					s_d.rpt_left = s_q.rpt_left - 4'h1;
					if (eff_mode == TM_PRE)
						s_d.st = ST_CSTART;
					else
					begin
						s_d.st = ST_TRACK;
						s_d.cnt = track_init;
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		if (!en)
		begin
			s_d.st = ST_IDLE;
			s_d.powered = 1'b0;
		end

		// A finishing conversion beats a simultaneous software clear
		if (done_clr)
			s_d.done = 1'b0;
		if (s_q.st == ST_FINISH && s_q.rpt_left == 4'h0 && en)
			s_d.done = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.ctrl <= `ADCST_CTRL_RST;
			s_q.cfg <= `ADCST_CFG_RST;
		end
		else
			s_q <= s_d;
	end

	// Starts outside idle fall through the idle-only check above
	assign conversion_busy_bit = s_q.st != ST_IDLE;
	assign conversion_done_flag = s_q.done;
	assign eoc_irq_req = s_q.done && s_q.ctrl[`ADCST_C_EOCIE];
	assign window_irq_en = s_q.ctrl[`ADCST_C_WINIE];
	assign converter_powered = s_q.powered;
	assign sar_run = s_q.st == ST_CSTART || s_q.st == ST_CONV
		|| s_q.st == ST_FINISH;
	assign sar_step = step;
	// Post mode leaves the sampling switch open while idle
	assign track_en = s_q.powered && (s_q.st == ST_TRACK
		|| (s_q.st == ST_IDLE && eff_mode != TM_POST));

	assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_ok && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;

	logic [15:0] trk_cyc_q;
	logic [15:0] conv_cyc_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			trk_cyc_q <= 16'h0000;
			conv_cyc_q <= 16'h0000;
		end
		else
		begin
			trk_cyc_q <= s_q.st == ST_TRACK ? trk_cyc_q + 16'h0001
				: 16'h0000;
			// Cleared in finish too, so a pre-tracking repeat starts at zero
			if (s_q.st == ST_CSTART || s_q.st == ST_CONV)
				conv_cyc_q <= conv_cyc_q + 16'h0001;
			else
				conv_cyc_q <= 16'h0000;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_track_length: assert property (
		(s_q.st == ST_TRACK && s_q.cnt == 8'h00)
		|-> trk_cyc_q == {12'h000, s_q.cfg[`ADCST_G_TK]} + 16'h0001)
		else $error("tracking period length wrong");
	a_conv_length: assert property (
		(s_q.st == ST_FINISH) |-> conv_cyc_q == 16'(`ADCST_CONV_STEPS)
		* ({11'h000, s_q.cfg[`ADCST_G_DIV]} + 16'h0001) + 16'h0001)
		else $error("conversion length wrong");
	a_done_on_fall: assert property (
		$rose(conversion_done_flag) |-> $fell(conversion_busy_bit))
		else $error("done flag set without busy falling");
	a_result_stable: assert property (
		(conversion_done_flag && $past(conversion_done_flag))
		|-> $stable(s_q.result))
		else $error("result changed while done flag set");
	a_start_ignored: assert property (
		(conversion_busy_bit && start && en) |=> s_q.st != ST_PWRUP
		|| $past(s_q.st) == ST_PWRUP)
		else $error("start accepted while busy");
	a_pre_immediate: assert property (
		(s_q.st == ST_IDLE && en && start && eff_mode == TM_PRE)
		|=> s_q.st == ST_CSTART ##1 s_q.st == ST_CONV)
		else $error("pre-tracking did not convert at once");
	a_post_open: assert property (
		(eff_mode == TM_POST && !conversion_busy_bit) |-> !track_en)
		else $error("post-tracking input not disconnected");
	a_timer1_start: assert property (
		(s_q.st == ST_IDLE && en && src == SRC_T1 && timer1_ovf)
		|=> conversion_busy_bit)
		else $error("timer 1 overflow did not start");
	a_irq_follows: assert property (
		$rose(conversion_done_flag) && s_q.ctrl[`ADCST_C_EOCIE]
		|-> eoc_irq_req)
		else $error("interrupt request missing");
	a_resp_hold: assert property (
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response dropped early");

	c_post_done: cover property (
		eff_mode == TM_POST && $rose(conversion_done_flag));
	c_pre_done: cover property (
		eff_mode == TM_PRE && $rose(conversion_done_flag));
	c_burst_pwrup: cover property (s_q.st == ST_PWRUP ##1
		s_q.st == ST_TRACK);
	c_repeat: cover property (s_q.st == ST_FINISH && s_q.rpt_left != 4'h0);
endmodule

//--- src/adcst_trigger.sv
// Start source selection and edge detection for conversion starts.
// Assumes timer overflow inputs are one-cycle pulses, pins synchronous.
`timescale 1ns/10ps
module adcst_trigger
	import adcst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input adcst_src_type src,
	input wire logic sw_start,
	input wire logic external_convert_start,
	input wire logic timer1_ovf,
	input wire logic timer2_low_ovf,
	input wire logic timer2_high_ovf,
	input wire logic timer2_split_mode,
	output logic start
);
	adcst_trig_state_type s_q;
	adcst_trig_state_type s_d;
	logic ext_rise;
	logic t2_ovf;

	always_comb
	begin
		s_d = s_q;
		s_d.ext_prev = external_convert_start;
	end

	assign ext_rise = external_convert_start && !s_q.ext_prev;
	// Split timer counts on its low byte, full timer on its high byte
	assign t2_ovf = timer2_split_mode ? timer2_low_ovf
		: timer2_high_ovf;

	always_comb
	begin
		case (src)
			SRC_SW: start = sw_start;
			SRC_EXT: start = ext_rise;
			SRC_T1: start = timer1_ovf;
			SRC_T2: start = t2_ovf;
			default: start = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

//--- verif/adc_conversion_start_tracking_tb.sv
// Self-checking bench: AXI4-Lite register tasks and conversion scenarios.
// Assumes the partner model drives timers, pin and the analog result.
`timescale 1ns/10ps
`include "adcst_defines.svh"
`define CHK(nm, ex, gt) \
	begin \
		checked++; \
		if ((gt) !== (ex)) \
		begin \
			fail_count++; \
			$display("[ERR] %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module adc_conversion_start_tracking_tb
	import adcst_pkg::*;
;
	localparam logic [11:0] SAMPLE = 12'h5a3;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd, ctrl_v;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic k1 = 1'b0, k2l = 1'b0, k2h = 1'b0, pin = 1'b0, split = 1'b0;
	logic busy_d = 1'b0;
	logic [1:0] resp;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic t1, t2l, t2h, ext, busy, done, irq, winen, trk, run, step, pwr;
	wire logic [11:0] sres;
	int fail_count = 0, checked = 0, busy_n = 0, rise_n = 0, step_n = 0;

	adcst_top DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_convert_start(ext), .timer1_ovf(t1),
		.timer2_low_ovf(t2l), .timer2_high_ovf(t2h),
		.timer2_split_mode(split), .sar_result(sres),
		.conversion_busy_bit(busy), .conversion_done_flag(done),
		.eoc_irq_req(irq), .window_irq_en(winen), .track_en(trk),
		.sar_run(run), .sar_step(step), .converter_powered(pwr));

	adcst_partner #(.SAMPLE(SAMPLE)) far (.aclk(aclk), .kick_t1(k1),
		.kick_t2l(k2l), .kick_t2h(k2h), .pin_req(pin), .sar_run(run),
		.timer1_ovf(t1), .timer2_low_ovf(t2l), .timer2_high_ovf(t2h),
		.external_convert_start(ext), .sar_result(sres));

	always #20 aclk = ~aclk;

	// Running totals; scenarios compare differences, never absolute values
	always @(posedge aclk)
	begin
		busy_d <= busy;
		if (busy === 1'b1)
			busy_n <= busy_n + 1;
		if (busy === 1'b1 && busy_d !== 1'b1)
			rise_n <= rise_n + 1;
		if (step === 1'b1)
			step_n <= step_n + 1;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		@(posedge aclk);
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (aw && awready === 1'b1)
			begin
				aw = 0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1)
			begin
				w = 0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		bit pend;
		@(posedge aclk);
		pend = 1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (pend && arready === 1'b1)
			begin
				pend = 0;
				arvalid <= 1'b0;
			end
		end
		while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic kick(input int w);
		@(posedge aclk);
		k1 <= (w == 0);
		k2l <= (w == 1);
		k2h <= (w == 2);
		@(posedge aclk);
		k1 <= 1'b0;
		k2l <= 1'b0;
		k2h <= 1'b0;
	endtask

	// Source 4 pulses the timer 2 byte that the current mode must ignore
	task automatic conv(input int src, input int starts, input int len,
		input int steps, input bit dup);
		int s, r, p, n;
		s = busy_n;
		r = rise_n;
		p = step_n;
		n = 0;
		case (src)
			0: wr(`ADCST_OFF_CTRL, ctrl_v | 32'h2);
			1:
			begin
				@(posedge aclk);
				pin <= 1'b1;
				repeat (3) @(posedge aclk);
				pin <= 1'b0;
			end
			2: kick(0);
			3: kick(split ? 1 : 2);
			default: kick(split ? 2 : 1);
		endcase
		if (dup)
			kick(0);
		while (n < 2000 && (starts == 0 ? n < 40 : !(rise_n > r &&
			busy === 1'b0 && done === 1'b1)))
		begin
			@(posedge aclk);
			n++;
		end
		`CHK("starts", starts, rise_n - r)
		`CHK("busy_len", len, busy_n - s)
		`CHK("steps", steps, step_n - p)
		if (starts == 1)
			`CHK("done", 1'b1, done)
	endtask

	function automatic int tlen(input int m, input int tk, input int d);
		return (m == 2 ? 0 : tk + 2) + 2 + 13 * (d + 1);
	endfunction

	initial
	begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		end_of_test();
	end

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(`ADCST_OFF_CTRL);
		`CHK("ctrl_reset", 32'h0, rd)
		rdr(`ADCST_OFF_CFG);
		`CHK("cfg_reset", 32'h1, rd)
		rdr(8'h10);
		`CHK("unmapped_data", 32'h0, rd)
		`CHK("unmapped_rresp", `ADCST_RESP_SLVERR, resp)
		wr(8'h14, 32'hffff_ffff);
		`CHK("unmapped_bresp", `ADCST_RESP_SLVERR, resp)
		wr(`ADCST_OFF_CFG, 32'hffff_ffff);
		rdr(`ADCST_OFF_CFG);
		`CHK("cfg_mask", 32'hff01_1f3f, rd)
		$display("test registers done");
		ctrl_v = 32'h41;
		// Enable must already stand when the busy bit is written
		wr(`ADCST_OFF_CTRL, ctrl_v);
		for (int m = 0; m < 4; m++)
		begin
			wr(`ADCST_OFF_CFG, m | 32'h10c);
			// Let the input settle before a pre-tracking start
			repeat (8) @(posedge aclk);
			conv(0, 1, tlen(m, 3, 1), 13, 0);
			`CHK("track_idle", (m > 1), trk)
			`CHK("eoc_irq", 1'b1, irq)
			rdr(`ADCST_OFF_RESULT);
			`CHK("result", {20'h0, SAMPLE}, rd)
			rdr(`ADCST_OFF_STATUS);
			`CHK("status", 32'h10 | ((m > 1) << 3), rd)
		end
		wr(`ADCST_OFF_CTRL, 32'h5);
		`CHK("irq_masked", 1'b0, irq)
		`CHK("done_kept", 1'b1, done)
		$display("test tracking modes done");
		wr(`ADCST_OFF_CFG, 32'h1);
		for (int k = 1; k < 4; k++)
		begin
			ctrl_v = 32'h1 | (k << 4);
			// Mode settles during the write, before the kick is chosen
			split <= (k == 3);
			wr(`ADCST_OFF_CTRL, ctrl_v);
			conv(k, 1, 17, 13, 0);
			conv(k == 3 ? 4 : 0, 0, 0, 0, 0);
		end
		split <= 1'b0;
		// Clears the done flag so the next result lands on a fresh flag
		wr(`ADCST_OFF_CTRL, ctrl_v);
		conv(3, 1, 17, 13, 0);
		ctrl_v = 32'h21;
		wr(`ADCST_OFF_CTRL, ctrl_v);
		conv(2, 1, 17, 13, 1);
		$display("test start sources done");
		ctrl_v = 32'h1;
		wr(`ADCST_OFF_CTRL, ctrl_v);
		wr(`ADCST_OFF_CFG, 32'h1_0001);
		conv(0, 1, 68, 52, 0);
		rdr(`ADCST_OFF_RESULT);
		`CHK("repeat_sum", 32'h168c, rd)
		ctrl_v = 32'h401;
		wr(`ADCST_OFF_CFG, 32'h1);
		conv(0, 1, 17, 13, 0);
		rdr(`ADCST_OFF_RESULT);
		`CHK("left_just", {16'h0, SAMPLE, 4'h0}, rd)
		$display("test repeat and justify done");
		ctrl_v = 32'h181;
		// Disable first so burst starts from the unpowered state
		wr(`ADCST_OFF_CTRL, 32'h180);
		wr(`ADCST_OFF_CTRL, ctrl_v);
		`CHK("window_en", 1'b1, winen)
		wr(`ADCST_OFF_CFG, 32'h0200_0001);
		conv(0, 1, 20, 13, 0);
		`CHK("powered", 1'b1, pwr)
		wr(`ADCST_OFF_CFG, 32'h0200_0002);
		conv(0, 1, 17, 13, 0);
		// Low-power idle drops power, so every start pays the power-up
		ctrl_v = 32'h381;
		wr(`ADCST_OFF_CTRL, ctrl_v);
		conv(0, 1, 20, 13, 0);
		@(posedge aclk);
		`CHK("idle_off", 1'b0, pwr)
		$display("test burst done");
		end_of_test();
	end
endmodule

//--- verif/adcst_partner.sv
// Far-side model: the two timers, the start pin and the analog core.
// Assumes the bench raises each kick input for exactly one clock cycle.
`timescale 1ns/10ps
module adcst_partner
#(
	parameter logic [11:0] SAMPLE = 12'h5a3
)
(
	input wire logic aclk,
	input wire logic kick_t1,
	input wire logic kick_t2l,
	input wire logic kick_t2h,
	input wire logic pin_req,
	input wire logic sar_run,
	output logic timer1_ovf = 1'b0,
	output logic timer2_low_ovf = 1'b0,
	output logic timer2_high_ovf = 1'b0,
	output logic external_convert_start = 1'b0,
	output logic [11:0] sar_result
);
	// Overflows are one-cycle pulses, the pin is a plain level
	always @(posedge aclk)
	begin
		timer1_ovf <= kick_t1;
		timer2_low_ovf <= kick_t2l;
		timer2_high_ovf <= kick_t2h;
		external_convert_start <= pin_req;
	end
	// Answer only while converting; inverted outside to expose early sampling
	assign sar_result = sar_run ? SAMPLE : ~SAMPLE;
endmodule
